/* hdl/bss_lane.v */
// byte-enable mux, write lane select and read lane steering
`timescale 1ns/1ps
`default_nettype none
module bss_lane #(
  parameter NDW = 32,
  parameter BDW = 64,
  parameter AW = 32
) (
  input wire [AW-1:0] cur_addr,
  input wire [BDW/8-1:0] bus_be,
  input wire [BDW-1:0] bus_wdata,
  input wire [NDW-1:0] nat_rdata,
  output wire [NDW/8-1:0] nat_be,
  output wire [NDW-1:0] nat_wdata,
  output wire [BDW-1:0] bus_rdata
);
  localparam R = BDW / NDW;
  localparam NBL = $clog2(NDW / 8);
  localparam LW = (R > 1) ? $clog2(R) : 1;
  wire [LW-1:0] lane;
  genvar g;
  assign lane = (R > 1) ? cur_addr[NBL +: LW] : {LW{1'b0}};
  assign nat_be = bus_be[lane*(NDW/8) +: NDW/8];
  assign nat_wdata = bus_wdata[lane*NDW +: NDW];
  // read data copied onto every lane so any master width finds it
  generate
    for (g = 0; g < R; g = g + 1) begin : g_rd
      assign bus_rdata[g*NDW +: NDW] = nat_rdata;
    end
  endgenerate
endmodule // bss_lane
`default_nettype wire

/* hdl/bss_slave_attach.v */
// burst-capable slave bus attachment toward user logic
// Function
// - accept single, fixed bursts up to 16 beats, and cachelines; pass to user
// - cacheline read order selectable: target word first or line start first
// - burst length less one of current transfer shown on burst_beat_count
// - data phase unacknowledged for 128 cycles is ended by internal timeout
// - bursts never end early; every announced beat completes
// - user may accept address ahead of and apart from data acknowledges
// - burst flag, beat requests, length and address accept only here
// - width mismatch: burst length expansion, byte-enable mux, read steering
// - 32-bit address, native data 32, 64 or 128, bus width a power-of-two multiple of native
// - read and write faults reported on separate outputs
`timescale 1ns/1ps
`default_nettype none
`include "bss_regs.vh"
module bss_slave_attach #(
  parameter AW = 32,
  parameter NDW = 32,
  parameter BDW = 64,
  parameter NCE = 4,
  parameter CL_WORDS = 8,
  parameter TWF = 1
) (
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  input wire bus_req_valid,
  output wire bus_req_ready,
  input wire [AW-1:0] bus_req_addr,
  input wire bus_req_rnw,
  input wire [1:0] bus_req_type,
  input wire [3:0] bus_req_len,
  input wire [1:0] bus_req_ratio,
  input wire [BDW/8-1:0] bus_req_be,
  input wire [BDW-1:0] bus_wdata,
  output reg sl_addr_ack,
  output reg sl_wr_ack,
  output reg sl_rd_ack,
  output reg [BDW-1:0] sl_rd_data,
  output reg slave_read_fault,
  output reg slave_write_fault,
  output wire sl_busy,
  output reg user_cs,
  output reg [NCE-1:0] user_rd_ce,
  output reg [NCE-1:0] user_wr_ce,
  output reg [AW-1:0] user_addr,
  output reg user_rnw,
  output reg [NDW/8-1:0] user_be,
  output reg [NDW-1:0] user_wdata,
  output reg burst_flag_out,
  output reg read_beat_request,
  output reg write_beat_request,
  output reg [`BSS_CNT_W-1:0] burst_beat_count,
  input wire user_addr_accept,
  input wire user_read_accept,
  input wire user_write_accept,
  input wire user_fault_flag,
  input wire [NDW-1:0] user_rdata
);
  // ----------------------------------------
  // derived widths
  // ----------------------------------------
  localparam NB = NDW / 8;
  localparam NBL = $clog2(NB);
  localparam CLW = $clog2(CL_WORDS);
  localparam CEW = (NCE > 1) ? $clog2(NCE) : 1;
  localparam [AW-1:0] LMASK = CL_WORDS * NB - 1;
  localparam [`BSS_CNT_W-1:0] CLCNT = CL_WORDS;

  reg [1:0] st_r;
  reg [1:0] type_r;
  reg rnw_r;
  reg [AW-1:0] base_r;
  reg [BDW/8-1:0] be_r;
  reg [`BSS_CNT_W-1:0] total_r;
  reg [`BSS_CNT_W-1:0] idx_r;
  reg [`BSS_CNT_W-1:0] tout_r;
  reg addr_done_r;
  reg [`BSS_CNT_W-1:0] total_nxt;
  reg [AW-1:0] cur_addr;
  reg [CLW-1:0] word;
  reg [CLW-1:0] start_word;
  wire [NDW/8-1:0] nat_be;
  wire [NDW-1:0] nat_wdata;
  wire [BDW-1:0] bus_rdata;
  wire ack;
  wire tout_hit;
  wire beat_done;
  wire beat_fault;
  wire last;
  wire [CEW-1:0] ce_idx;

  // ----------------------------------------
  // beat address generation
  // ----------------------------------------
  always @* begin
    start_word = TWF ? base_r[NBL +: CLW] : {CLW{1'b0}};
    word = start_word + idx_r[CLW-1:0];
    if (type_r == `BSS_TYPE_LINE) begin
      cur_addr = (base_r & ~LMASK) |
        ({{(AW-CLW){1'b0}}, word} << NBL);
    end else begin
      cur_addr = base_r + ({{(AW-`BSS_CNT_W){1'b0}}, idx_r} << NBL);
    end
  end

  // beats counted in native words; a wider master's beats expand
  always @* begin
    case (bus_req_type)
      `BSS_TYPE_BURST: begin
        total_nxt = ({4'h0, bus_req_len} + `BSS_ONE) <<
          bus_req_ratio;
      end
      `BSS_TYPE_LINE: begin
        total_nxt = CLCNT;
      end
      default: begin
        total_nxt = `BSS_ONE;
      end
    endcase
  end

  bss_lane #(
    .NDW(NDW),
    .BDW(BDW),
    .AW(AW)
  ) u_lane (
    .cur_addr(cur_addr),
    .bus_be(be_r),
    .bus_wdata(bus_wdata),
    .nat_rdata(user_rdata),
    .nat_be(nat_be),
    .nat_wdata(nat_wdata),
    .bus_rdata(bus_rdata)
  );

  // ----------------------------------------
  // beat completion
  // ----------------------------------------
  assign bus_req_ready = (st_r == `BSS_ST_IDLE);
  assign sl_busy = (st_r != `BSS_ST_IDLE);
  assign ack = rnw_r ? user_read_accept : user_write_accept;
  // no suppress input: a hung user cannot stall the bus forever
  assign tout_hit = (tout_r == `BSS_TOUT_CYC - `BSS_ONE);
  assign beat_done = (st_r == `BSS_ST_DATA) && (ack || tout_hit);
  assign beat_fault = ack ? user_fault_flag : tout_hit;
  assign last = (idx_r == total_r - `BSS_ONE);
  assign ce_idx = cur_addr[NBL +: CEW];

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= `BSS_ST_IDLE;
      type_r <= `BSS_TYPE_SINGLE;
      rnw_r <= 1'b0;
      base_r <= {AW{1'b0}};
      be_r <= {(BDW/8){1'b0}};
      total_r <= `BSS_ONE;
      idx_r <= {`BSS_CNT_W{1'b0}};
      tout_r <= {`BSS_CNT_W{1'b0}};
      addr_done_r <= 1'b0;
      sl_addr_ack <= 1'b0;
      sl_wr_ack <= 1'b0;
      sl_rd_ack <= 1'b0;
      sl_rd_data <= {BDW{1'b0}};
      slave_read_fault <= 1'b0;
      slave_write_fault <= 1'b0;
      user_cs <= 1'b0;
      user_rd_ce <= {NCE{1'b0}};
      user_wr_ce <= {NCE{1'b0}};
      user_addr <= {AW{1'b0}};
      user_rnw <= 1'b0;
      user_be <= {NB{1'b0}};
      user_wdata <= {NDW{1'b0}};
      burst_flag_out <= 1'b0;
      read_beat_request <= 1'b0;
      write_beat_request <= 1'b0;
      burst_beat_count <= {`BSS_CNT_W{1'b0}};
    end else if (ce) begin
      sl_addr_ack <= 1'b0;
      sl_wr_ack <= 1'b0;
      sl_rd_ack <= 1'b0;
      slave_read_fault <= 1'b0;
      slave_write_fault <= 1'b0;
      // address taken once, by its own accept or the first data beat
      if (sl_busy && !addr_done_r &&
          (user_addr_accept || beat_done)) begin
        sl_addr_ack <= 1'b1;
        addr_done_r <= 1'b1;
      end
      case (st_r)
        `BSS_ST_IDLE: begin
          if (bus_req_valid) begin
            st_r <= `BSS_ST_LOAD;
            type_r <= bus_req_type;
            rnw_r <= bus_req_rnw;
            base_r <= bus_req_addr;
            be_r <= bus_req_be;
            total_r <= total_nxt;
            idx_r <= {`BSS_CNT_W{1'b0}};
            addr_done_r <= 1'b0;
            user_cs <= 1'b1;
            user_rnw <= bus_req_rnw;
            burst_flag_out <= (bus_req_type == `BSS_TYPE_BURST);
            burst_beat_count <= total_nxt - `BSS_ONE;
          end
        end
        `BSS_ST_LOAD: begin
          st_r <= `BSS_ST_DATA;
          tout_r <= {`BSS_CNT_W{1'b0}};
          user_addr <= cur_addr;
          // bursts and lines move whole words; singles use their lanes
          user_be <= (type_r == `BSS_TYPE_SINGLE) ?
            nat_be : {NB{1'b1}};
          user_wdata <= nat_wdata;
          user_rd_ce <= rnw_r ? ({{(NCE-1){1'b0}}, 1'b1} << ce_idx) :
            {NCE{1'b0}};
          user_wr_ce <= rnw_r ? {NCE{1'b0}} :
            ({{(NCE-1){1'b0}}, 1'b1} << ce_idx);
          read_beat_request <= rnw_r;
          write_beat_request <= !rnw_r;
        end
        `BSS_ST_DATA: begin
          tout_r <= tout_r + `BSS_ONE;
          if (beat_done) begin
            read_beat_request <= 1'b0;
            write_beat_request <= 1'b0;
            user_rd_ce <= {NCE{1'b0}};
            user_wr_ce <= {NCE{1'b0}};
            sl_rd_ack <= rnw_r;
            sl_wr_ack <= !rnw_r;
            sl_rd_data <= bus_rdata;
            slave_read_fault <= rnw_r & beat_fault;
            slave_write_fault <= !rnw_r & beat_fault;
            // a fault or timeout fails only this beat; the rest follow
            if (last) begin
              st_r <= `BSS_ST_IDLE;
              user_cs <= 1'b0;
              burst_flag_out <= 1'b0;
            end else begin
              st_r <= `BSS_ST_LOAD;
              idx_r <= idx_r + `BSS_ONE;
            end
          end
        end
        default: begin
          st_r <= `BSS_ST_IDLE;
        end
      endcase
    end
  end
endmodule // bss_slave_attach
`default_nettype wire

/* shared/bss_regs.vh */
// constants of the burst slave bus attachment
`ifndef BSS_REGS_VH
`define BSS_REGS_VH
// ----------------------------------------
// sequencer states
// ----------------------------------------
`define BSS_ST_IDLE 2'h0
`define BSS_ST_LOAD 2'h1
`define BSS_ST_DATA 2'h2
// ----------------------------------------
// transfer kinds on the bus request
// ----------------------------------------
`define BSS_TYPE_SINGLE 2'h0
`define BSS_TYPE_BURST 2'h1
`define BSS_TYPE_LINE 2'h2
// ----------------------------------------
// limits and timing
// ----------------------------------------
`define BSS_MAX_BEATS 8'h10
`define BSS_TOUT_CYC 8'h80
`define BSS_CNT_W 8
`define BSS_ONE 8'h01
`endif

/* tb/bss_props.sv */
// checker for the burst slave attachment
`timescale 1ns/1ps
`default_nettype none
`include "bss_regs.vh"
module bss_props (
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  input wire bus_req_valid,
  input wire user_read_accept,
  input wire user_write_accept,
  input wire user_fault_flag,
  input wire read_beat_request,
  input wire write_beat_request,
  input wire sl_rd_ack,
  input wire sl_wr_ack,
  input wire slave_read_fault,
  input wire slave_write_fault,
  input wire bus_req_ready,
  input wire sl_busy,
  input wire burst_flag_out,
  input wire user_cs,
  input wire [`BSS_CNT_W-1:0] burst_beat_count
);
  reg [7:0] wait_r;
  wire beat_req;
  assign beat_req = read_beat_request | write_beat_request;
  // cycles a beat has waited; only the timeout may end a silent wait
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 8'h00;
    end else begin
      wait_r <= beat_req ? wait_r + 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_rd_acked:
    assert property (read_beat_request && user_read_accept |=> sl_rd_ack)
    else $error("read accept lost");
  chk_wr_acked:
    assert property (write_beat_request && user_write_accept |=> sl_wr_ack)
    else $error("write accept lost");
  chk_wr_fault_pass:
    assert property (write_beat_request && user_write_accept &&
      user_fault_flag |=> slave_write_fault) else $error("fault lost");
  chk_rd_fault_split:
    assert property (slave_read_fault |-> sl_rd_ack && !slave_write_fault)
    else $error("read fault misplaced");
  chk_tout_bound:
    assert property (wait_r <= 8'h80) else $error("beat wait too long");
  chk_len_hold:
    assert property (burst_flag_out && $past(burst_flag_out) |->
      $stable(burst_beat_count)) else $error("burst length moved");
  chk_beat_in_cs:
    assert property (beat_req |-> user_cs)
    else $error("beat outside select");
  chk_ready_idle:
    assert property (ce && bus_req_valid && bus_req_ready |=>
      user_cs && sl_busy && !bus_req_ready) else $error("request not taken");
  cover property (wait_r == 8'h7f);
  cover property (sl_rd_ack && burst_flag_out);
  cover property (sl_wr_ack && burst_beat_count == 8'h0f);
endmodule // bss_props
bind bss_slave_attach bss_props chk_u (.clk_sys, .rst_n, .ce, .bus_req_valid,
  .user_read_accept,
  .user_write_accept, .user_fault_flag, .read_beat_request,
  .write_beat_request, .sl_rd_ack, .sl_wr_ack, .slave_read_fault,
  .slave_write_fault, .bus_req_ready, .sl_busy, .burst_flag_out, .user_cs,
  .burst_beat_count);
`default_nettype wire

/* tb/bss_slave_attach_bench.sv */
// self-checking bench for the burst slave attachment
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module bss_slave_attach_bench;
  logic clk_sys = 0, rst_n = 0, bus_req_valid = 0, bus_req_rnw = 0, flt = 0;
  logic ce = 1;
  logic [31:0] bus_req_addr = 0;
  logic [1:0] bus_req_type = 0, bus_req_ratio = 0;
  logic [3:0] bus_req_len = 0;
  logic [7:0] dly = 0;
  logic [63:0] bus_wdata = 64'hc3c3_a5a5_3c3c_5a5a;
  int err_count = 0, checks_done = 0;
  wire bus_req_ready, sl_addr_ack, sl_wr_ack, sl_rd_ack, slave_read_fault;
  wire slave_write_fault, sl_busy, user_cs, burst_flag_out, read_beat_request;
  wire write_beat_request, user_addr_accept, user_read_accept;
  wire user_write_accept, user_fault_flag;
  wire [63:0] sl_rd_data;
  wire [31:0] user_addr, user_wdata, user_rdata;
  wire user_rnw;
  wire [3:0] user_rd_ce, user_wr_ce, user_be;
  wire [7:0] burst_beat_count;
  // row: beats-1, rnw, type, len, ratio, address
  logic [55:0] rows [8] = '{56'h00000000000104, 56'h0010000000010c,
    56'h03113000000200, 56'h0f01f000000300, 56'h03111100000400,
    56'h07120000000514, 56'h07020000000608, 56'h00130000000700};
  bss_slave_attach dut_u (.clk_sys, .rst_n, .ce, .bus_req_valid,
    .bus_req_ready, .bus_req_addr, .bus_req_rnw, .bus_req_type, .bus_req_len,
    .bus_req_ratio, .bus_req_be(8'h3c), .bus_wdata, .sl_addr_ack, .sl_wr_ack,
    .sl_rd_ack, .sl_rd_data, .slave_read_fault, .slave_write_fault, .sl_busy,
    .user_cs, .user_rd_ce, .user_wr_ce, .user_addr, .user_rnw,
    .user_be, .user_wdata, .burst_flag_out, .read_beat_request,
    .write_beat_request, .burst_beat_count, .user_addr_accept,
    .user_read_accept, .user_write_accept, .user_fault_flag, .user_rdata);
  bss_user_model mdl_u (.clk_sys, .rst_n, .user_cs, .rd_req(read_beat_request),
    .wr_req(write_beat_request), .flt, .addr(user_addr), .dly,
    .addr_acc(user_addr_accept), .rd_acc(user_read_accept),
    .wr_acc(user_write_accept), .fault(user_fault_flag), .rdata(user_rdata));
  initial forever #2.5 clk_sys = ~clk_sys;
  task end_sim;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk_rst;
    `CHK(({bus_req_ready, sl_busy, user_cs, burst_flag_out}), 4'h8)
    `CHK(({read_beat_request, write_beat_request}), 2'h0)
    `CHK(burst_beat_count, 8'h00)
  endtask
  task automatic start(input [55:0] r);
    {bus_req_rnw, bus_req_type, bus_req_len, bus_req_ratio} =
      {r[44], r[41:40], r[39:36], r[33:32]};
    bus_req_addr = r[31:0];
    bus_req_valid = 1;
    @(posedge clk_sys);
    #1 bus_req_valid = 0;
  endtask
  task automatic xfer(input [55:0] r, input [7:0] d, input f);
    logic [31:0] ea, wd;
    logic [3:0] oh, eb;
    logic [7:0] exp_ce;
    logic [1:0] ef;
    int n, na, k;
    n = 0;
    na = 0;
    dly = d;
    flt = f;
    ef = {r[44], ~r[44]} & {2{f | (d == 8'hff)}};
    start(r);
    `CHK(burst_beat_count, r[55:48])
    `CHK(burst_flag_out, r[41:40] == 2'h1)
    for (k = 0; k < 4000; k++) begin
      if (bus_req_ready && n > r[55:48]) break;
      ea = r[41] ? {r[31:5], r[4:2] + n[2:0], 2'b00} : r[31:0] + 4 * n;
      wd = ea[2] ? bus_wdata[63:32] : bus_wdata[31:0];
      oh = 4'h1 << ea[3:2];
      exp_ce = r[44] ? {oh, 4'h0} : {4'h0, oh};
      // singles steer the 8'h3c enables by lane, all other kinds get all
      eb = (r[41:40] != 2'h0) ? 4'hf : (ea[2] ? 4'h3 : 4'hc);
      if (user_read_accept | user_write_accept) begin
        `CHK(user_addr, ea)
        `CHK(user_rnw, r[44])
        `CHK(user_be, eb)
        `CHK(({user_rd_ce, user_wr_ce}), exp_ce)
      end
      if (user_write_accept) `CHK(user_wdata, wd)
      if (sl_rd_ack && d != 8'hff) `CHK(sl_rd_data, {2{ea}})
      if (sl_rd_ack | sl_wr_ack) begin
        `CHK(({slave_read_fault, slave_write_fault}), ef)
        n++;
      end
      na += sl_addr_ack;
      @(posedge clk_sys);
      #1;
    end
    if (k == 4000) begin
      err_count++;
      end_sim;
    end
    `CHK(n, r[55:48] + 1)
    `CHK(na, 1)
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    #1 chk_rst;
    rst_n = 1;
    // clock enable low: a standing request must not be taken
    ce = 0;
    bus_req_valid = 1;
    repeat (3) @(posedge clk_sys);
    #1 `CHK(({user_cs, bus_req_ready}), 2'h1)
    ce = 1;
    for (int i = 0; i < 8; i++) xfer(rows[i], 8'(i % 3), 1'b0);
    xfer(rows[1], 8'hff, 1'b0);
    // both beats time out, the burst still runs to its end
    xfer(56'h01111000000800, 8'hff, 1'b0);
    xfer(56'h03013000000900, 8'h01, 1'b1);
    start(rows[3]);
    repeat (4) @(posedge clk_sys);
    #1 rst_n = 0;
    #1 chk_rst;
    repeat (3) @(posedge clk_sys);
    #1 rst_n = 1;
    xfer(rows[5], 8'h02, 1'b0);
    end_sim;
  end
endmodule // bss_slave_attach_bench
`default_nettype wire

/* tb/bss_user_model.sv */
// user logic model answering beat requests after a set delay
`timescale 1ns/1ps
`default_nettype none
module bss_user_model (
  input wire clk_sys,
  input wire rst_n,
  input wire user_cs,
  input wire rd_req,
  input wire wr_req,
  input wire flt,
  input wire [31:0] addr,
  input wire [7:0] dly,
  output reg addr_acc,
  output reg rd_acc,
  output reg wr_acc,
  output wire fault,
  output wire [31:0] rdata
);
  reg [7:0] cnt_r;
  reg cs_r;
  // no retry, no occupied flag, every beat answered while dly is below 8'h7f; larger dly, such as 8'hff, outlasts the timeout
  // data only good with the accept, inverse otherwise
  assign rdata = rd_acc ? addr : ~addr;
  assign fault = flt & (rd_acc | wr_acc);
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {cnt_r, cs_r, addr_acc, rd_acc, wr_acc} <= 12'h000;
    end else begin
      cs_r <= user_cs;
      addr_acc <= user_cs & ~cs_r;
      cnt_r <= 8'h00;
      rd_acc <= 1'b0;
      wr_acc <= 1'b0;
      if ((rd_req | wr_req) & ~(rd_acc | wr_acc)) begin
        cnt_r <= cnt_r + 8'h01;
        rd_acc <= rd_req & (cnt_r == dly);
        wr_acc <= wr_req & (cnt_r == dly);
      end
    end
  end
endmodule // bss_user_model
`default_nettype wire
